/* src/uip_map.vh */
`ifndef UIP_MAP_VH
`define UIP_MAP_VH

// register addresses on the three-bit port
`define UIP_ADDR_HOLDING   3'h0
`define UIP_ADDR_ENABLE    3'h1
`define UIP_ADDR_STATUS    3'h2
`define UIP_ADDR_LINE      3'h5
`define UIP_ADDR_MODEM     3'h6

// interrupt_enable fields and reset value
`define UIP_IE_RX          0
`define UIP_IE_TX          1
`define UIP_IE_LINE        2
`define UIP_IE_MODEM       3
`define UIP_IE_RESET       4'h0

// interrupt_source_status codes, bits 3..0
`define UIP_CODE_LINE      4'h6
`define UIP_CODE_TIMEOUT   4'hC
`define UIP_CODE_RXDATA    4'h4
`define UIP_CODE_TXREADY   4'h2
`define UIP_CODE_MODEM     4'h0
`define UIP_CODE_NONE      4'h1

// line_status fields
`define UIP_LS_READY       0
`define UIP_LS_OVERRUN     1
`define UIP_LS_PARITY      2
`define UIP_LS_FRAMING     3
`define UIP_LS_BREAK       4
`define UIP_LS_TX_EMPTY    5
`define UIP_LS_ALL_EMPTY   6
`define UIP_LS_GLOBAL_ERR  7
`define UIP_LS_RESET       8'h60

// receive trigger levels
`define UIP_TRIG_SEL00     5'h01
`define UIP_TRIG_SEL01     5'h04
`define UIP_TRIG_SEL10     5'h08
`define UIP_TRIG_SEL11     5'h0E

// receive timeout: four characters plus twelve bit times
`define UIP_TO_CHARS       7'h04
`define UIP_TO_EXTRA_BITS  7'h0C

`endif

/* src/uip_rx_timer.v */
`timescale 1ns/1ps
`include "uip_map.vh"

module uip_rx_timer (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // control
  input  wire       restart,
  input  wire       armed,
  input  wire       bit_tick,
  input  wire [3:0] char_bits,
  // result
  output reg        expired
);

  reg  [6:0] count;
  reg        done;
  wire [6:0] limit;

  // frame length times four plus twelve, in bit times
  assign limit = (`UIP_TO_CHARS * {3'h0, char_bits}) + `UIP_TO_EXTRA_BITS;

  always @(posedge clk) begin
    if (rst) begin
      count   <= 7'h00;
      done    <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (restart || !armed) begin
        // an empty fifo never times out
        count <= 7'h00;
        done  <= 1'b0;
      end else if (bit_tick && !done) begin
        if (count == limit - 7'h01) begin
          done    <= 1'b1;
          expired <= 1'b1;
        end else begin
          count <= count + 7'h01;
        end
      end
    end
  end

endmodule // uip_rx_timer

/* src/uip_prioritizer.v */
`timescale 1ns/1ps
`include "uip_map.vh"

module uip_prioritizer #(
  parameter DEPTH = 16,
  parameter CW    = 5
) (
  // clock and reset
  input  wire          clk,
  input  wire          rst,
  // host register port
  input  wire [2:0]    reg_addr,
  input  wire          reg_rd,
  input  wire          reg_wr,
  input  wire [7:0]    reg_wdata,
  output reg  [7:0]    reg_rdata,
  // configuration held elsewhere
  input  wire          divisor_access,
  input  wire          fifo_enable,
  input  wire [1:0]    trigger_sel,
  input  wire          irq_output_enable,
  input  wire [3:0]    char_bits,
  input  wire          bit_tick,
  // receive datapath
  input  wire          rx_push,
  input  wire [2:0]    rx_push_err,
  input  wire          rx_overrun,
  input  wire          rx_fifo_reset,
  input  wire [CW-1:0] rx_count,
  input  wire [2:0]    rx_head_err,
  // transmit datapath
  input  wire          tx_fifo_empty,
  input  wire          tx_shift_empty,
  // modem change bits
  input  wire [3:0]    modem_delta,
  // status and interrupt pin
  output reg  [7:0]    line_status,
  output reg           irq_out,
  output reg           irq_oe
);

  // trigger field to character count
  function [CW-1:0] trig_level;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   trig_level = `UIP_TRIG_SEL00;
        2'b01:   trig_level = `UIP_TRIG_SEL01;
        2'b10:   trig_level = `UIP_TRIG_SEL10;
        2'b11:   trig_level = `UIP_TRIG_SEL11;
        default: trig_level = `UIP_TRIG_SEL00;
      endcase
    end
  endfunction

  // host access decode
  wire rd_holding = reg_rd && reg_addr == `UIP_ADDR_HOLDING && !divisor_access;
  wire wr_holding = reg_wr && reg_addr == `UIP_ADDR_HOLDING && !divisor_access;
  wire rd_enable  = reg_rd && reg_addr == `UIP_ADDR_ENABLE && !divisor_access;
  wire wr_enable  = reg_wr && reg_addr == `UIP_ADDR_ENABLE && !divisor_access;
  wire rd_status  = reg_rd && reg_addr == `UIP_ADDR_STATUS;
  wire rd_line    = reg_rd && reg_addr == `UIP_ADDR_LINE;
  wire rd_modem   = reg_rd && reg_addr == `UIP_ADDR_MODEM;

  reg  [3:0]    interrupt_enable;
  reg           overrun_flag;
  reg  [CW-1:0] err_count;
  reg           head_new;
  reg           line_pend;
  reg           timeout_pend;
  reg           tx_pend;
  reg           modem_pend;
  reg           tx_empty_q;
  reg  [3:0]    modem_delta_q;
  reg           tx_pend_en_q;
  reg           modem_pend_en_q;
  reg  [3:0]    code;
  wire          timer_expired;
  wire          rx_nonempty = rx_count != {CW{1'b0}};
  wire          rx_data_pend;
  wire          any_pend;
  wire [7:0]    interrupt_source_status;
  wire [7:0]    next_line_status;
  wire          next_tx_pend;

  // enable register, only the low nibble exists
  always @(posedge clk) begin
    if (rst) begin
      interrupt_enable <= `UIP_IE_RESET;
    end else if (wr_enable) begin
      interrupt_enable <= reg_wdata[3:0];
    end
  end

  // receive data: level-driven, clears itself as fifo drains
  assign rx_data_pend = interrupt_enable[`UIP_IE_RX] &&
    (fifo_enable ? (rx_count >= trig_level(trigger_sel))
                 : rx_nonempty);

  uip_rx_timer u_timer (
    .clk       (clk),
    .rst       (rst),
    .restart   (rx_push || rd_holding),
    .armed     (rx_nonempty && fifo_enable),
    .bit_tick  (bit_tick),
    .char_bits (char_bits),
    .expired   (timer_expired)
  );

  // timeout: set wins over the clearing read
  always @(posedge clk) begin
    if (rst) begin
      timeout_pend <= 1'b0;
    end else if (timer_expired && interrupt_enable[`UIP_IE_RX] && fifo_enable) begin
      timeout_pend <= 1'b1;
    end else if (rd_holding || !interrupt_enable[`UIP_IE_RX]) begin
      timeout_pend <= 1'b0;
    end
  end

  // overrun flag sticks until line status is read
  always @(posedge clk) begin
    if (rst) begin
      overrun_flag <= 1'b0;
    end else if (rx_overrun) begin
      overrun_flag <= 1'b1;
    end else if (rd_line) begin
      overrun_flag <= 1'b0;
    end
  end

  // count of errored characters held in the fifo
  always @(posedge clk) begin
    if (rst || rx_fifo_reset) begin
      err_count <= {CW{1'b0}};
    end else begin
      case ({rx_push && (rx_push_err != 3'h0), rd_holding && rx_nonempty && (rx_head_err != 3'h0)})
        2'b10:   err_count <= err_count + {{CW-1{1'b0}}, 1'b1};
        2'b01:   err_count <= err_count - {{CW-1{1'b0}}, 1'b1};
        default: err_count <= err_count;
      endcase
    end
  end

  // head changes on a read, or on a push into an empty fifo;
  // head error bits are looked at one cycle later once settled
  always @(posedge clk) begin
    if (rst) begin
      head_new <= 1'b0;
    end else begin
      head_new <= (rd_holding && rx_nonempty) || (rx_push && !rx_nonempty);
    end
  end

  // line status interrupt, set wins over the clearing read
  always @(posedge clk) begin
    if (rst) begin
      line_pend <= 1'b0;
    end else if (interrupt_enable[`UIP_IE_LINE] && rx_overrun) begin
      line_pend <= 1'b1;
    end else if (interrupt_enable[`UIP_IE_LINE] && head_new && rx_nonempty &&
                 rx_head_err != 3'h0) begin
      line_pend <= 1'b1;
    end else if (rd_line || !interrupt_enable[`UIP_IE_LINE]) begin
      line_pend <= 1'b0;
    end
  end

  // transmit ready: edge of empty, or enable raised while empty
  assign next_tx_pend = interrupt_enable[`UIP_IE_TX] && tx_fifo_empty &&
                        (!tx_empty_q || !tx_pend_en_q);

  always @(posedge clk) begin
    if (rst) begin
      tx_empty_q   <= 1'b1;
      tx_pend_en_q <= 1'b0;
      tx_pend      <= 1'b0;
    end else begin
      tx_empty_q   <= tx_fifo_empty;
      tx_pend_en_q <= interrupt_enable[`UIP_IE_TX];
      if (next_tx_pend) begin
        tx_pend <= 1'b1;
      end else if (wr_holding || (rd_status && code == `UIP_CODE_TXREADY) ||
                   !interrupt_enable[`UIP_IE_TX]) begin
        tx_pend <= 1'b0;
      end
    end
  end

  // modem: new change bit sets, modem status read clears
  always @(posedge clk) begin
    if (rst) begin
      modem_delta_q <= 4'h0;
      modem_pend    <= 1'b0;
    end else begin
      modem_delta_q <= modem_delta;
      if (interrupt_enable[`UIP_IE_MODEM] &&
          ((modem_delta & ~modem_delta_q) != 4'h0 ||
           (!modem_pend_en_q && modem_delta != 4'h0))) begin
        modem_pend <= 1'b1;
      end else if (rd_modem || !interrupt_enable[`UIP_IE_MODEM]) begin
        modem_pend <= 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      modem_pend_en_q <= 1'b0;
    end else begin
      modem_pend_en_q <= interrupt_enable[`UIP_IE_MODEM];
    end
  end

  // priority encoder; lower sources stay pending underneath
  always @* begin
    if (line_pend) begin
      code = `UIP_CODE_LINE;
    end else if (timeout_pend) begin
      code = `UIP_CODE_TIMEOUT;
    end else if (rx_data_pend) begin
      code = `UIP_CODE_RXDATA;
    end else if (tx_pend) begin
      code = `UIP_CODE_TXREADY;
    end else if (modem_pend) begin
      code = `UIP_CODE_MODEM;
    end else begin
      code = `UIP_CODE_NONE;
    end
  end

  assign any_pend = code != `UIP_CODE_NONE;
  // only the top source is reported per read
  assign interrupt_source_status = {fifo_enable, fifo_enable, 2'b00, code};

  // polled mode needs nothing beyond these flags
  assign next_line_status = {
    err_count != {CW{1'b0}},
    tx_fifo_empty && tx_shift_empty,
    tx_fifo_empty,
    rx_nonempty ? rx_head_err : 3'h0,
    overrun_flag,
    rx_nonempty
  };

  // outputs from flip-flops
  always @(posedge clk) begin
    if (rst) begin
      line_status <= `UIP_LS_RESET;
      irq_out     <= 1'b0;
      irq_oe      <= 1'b0;
    end else begin
      line_status <= next_line_status;
      irq_out     <= any_pend;
      irq_oe      <= irq_output_enable;
    end
  end

  // read data: captured on the strobe, valid the next cycle
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (rd_enable) begin
        reg_rdata <= {4'h0, interrupt_enable};
      end else if (rd_status) begin
        reg_rdata <= interrupt_source_status;
      end else if (rd_line) begin
        reg_rdata <= next_line_status;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

endmodule // uip_prioritizer

/* tb/uip_host.sv */
`timescale 1ns/1ps
module uip_host (
  // clock
  input  wire       clk,
  // register port
  output reg  [2:0] reg_addr,
  output reg        reg_rd,
  output reg        reg_wr,
  output reg  [7:0] reg_wdata,
  output reg        divisor_access,
  input  wire [7:0] reg_rdata
);
  initial begin
    reg_addr = 3'h0;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    divisor_access = 1'b0;
  end
  task dl(input v);
    begin
      @(negedge clk);
      divisor_access = v;
    end
  endtask
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      // idle bus must not look like the last write
      reg_wdata = ~d;
    end
  endtask
  task rd(input [2:0] a, output [7:0] q);
    begin
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      q = reg_rdata;
    end
  endtask
endmodule // uip_host

/* tb/uip_prioritizer_asserts.sv */
`timescale 1ns/1ps
module uip_prioritizer_asserts #(
  parameter CW = 5
) (
  // clock and reset
  input wire          clk,
  input wire          rst,
  // inputs
  input wire [2:0]    reg_addr,
  input wire          reg_wr,
  input wire [7:0]    reg_wdata,
  input wire          divisor_access,
  input wire          fifo_enable,
  input wire [1:0]    trigger_sel,
  input wire          irq_output_enable,
  input wire          rx_push,
  input wire          rx_overrun,
  input wire [CW-1:0] rx_count,
  input wire          tx_fifo_empty,
  input wire          tx_shift_empty,
  input wire [3:0]    modem_delta,
  // outputs
  input wire [7:0]    line_status,
  input wire          irq_out,
  input wire          irq_oe
);
  reg  [3:0]    ie;
  reg  [1:0]    quiet;
  wire          ie_wr = reg_wr && reg_addr == 3'h1 && !divisor_access;
  wire          md_any = |modem_delta;
  wire [CW-1:0] trig = trigger_sel == 2'h3 ? 5'h0E : trigger_sel == 2'h2 ? 5'h08 :
                       trigger_sel == 2'h1 ? 5'h04 : 5'h01;

  // shadow of the enables, quiet counts cycles with all of them off
  always @(posedge clk) begin
    if (rst) begin
      ie <= 4'h0;
      quiet <= 2'h0;
    end else begin
      if (ie_wr)
        ie <= reg_wdata[3:0];
      quiet <= (ie != 4'h0) ? 2'h0 : ((quiet == 2'h3) ? quiet : quiet + 2'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_reset_values: assert property ($fell(rst) |-> !irq_out && !irq_oe)
    else $error("interrupt pin not idle after reset");
  a_pin_enable: assert property (##1 irq_oe == $past(irq_output_enable))
    else $error("pin drive does not follow output enable");
  a_ready_push: assert property (rx_push |=> line_status[0])
    else $error("data ready not set after push");
  a_tx_flags: assert property (##1 line_status[5] == $past(tx_fifo_empty) &&
    line_status[6] == ($past(tx_fifo_empty) && $past(tx_shift_empty)))
    else $error("transmit empty flags wrong");
  a_overrun_fast: assert property (rx_overrun && ie[2] |-> ##2 irq_out)
    else $error("overrun did not raise interrupt");
  a_trigger_level: assert property (fifo_enable && ie[0] && rx_count >= trig |-> ##[1:2] irq_out)
    else $error("trigger level reached without interrupt");
  a_modem_change: assert property (ie[3] && $rose(md_any) |-> ##[1:2] irq_out)
    else $error("modem change did not raise interrupt");
  a_tx_enable: assert property (ie_wr && reg_wdata[1] && tx_fifo_empty |-> ##[1:3] irq_out)
    else $error("enabling transmit ready while empty gave no interrupt");
  a_quiet_no_irq: assert property (quiet == 2'h3 |-> !irq_out)
    else $error("interrupt with all enables off");

  c_overrun: cover property (rx_overrun && ie[2]);
  c_modem: cover property (ie[3] && $rose(md_any));
  c_polled: cover property (quiet == 2'h3 && rx_count != 0);
endmodule // uip_prioritizer_asserts

bind uip_prioritizer uip_prioritizer_asserts #(.CW(CW)) u_chk (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .divisor_access(divisor_access), .fifo_enable(fifo_enable), .trigger_sel(trigger_sel),
  .irq_output_enable(irq_output_enable), .rx_push(rx_push), .rx_overrun(rx_overrun),
  .rx_count(rx_count), .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty),
  .modem_delta(modem_delta), .line_status(line_status), .irq_out(irq_out), .irq_oe(irq_oe));

/* tb/uip_prioritizer_tb.sv */
`timescale 1ns/1ps
module uip_prioritizer_tb;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg        fifo_enable = 1'b0;
  reg  [1:0] trigger_sel = 2'h0;
  reg        irq_output_enable = 1'b0;
  reg        bit_tick = 1'b0;
  reg        rx_push = 1'b0;
  reg  [2:0] rx_push_err = 3'h0;
  reg        rx_overrun = 1'b0;
  reg  [4:0] rx_count = 5'h00;
  reg  [2:0] rx_head_err = 3'h0;
  reg        tx_shift_empty = 1'b1;
  reg        tx_fifo_empty = 1'b1;
  reg  [3:0] modem_delta = 4'h0;
  wire [2:0] reg_addr;
  wire       reg_rd;
  wire       reg_wr;
  wire       divisor_access;
  wire [7:0] reg_wdata;
  wire [7:0] reg_rdata;
  wire [7:0] line_status;
  wire       irq_out;
  wire       irq_oe;
  reg  [7:0] q;
  integer    errors = 0;
  integer    checks = 0;
  integer    i;

  always #2 clk = ~clk;

  uip_host host (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .divisor_access(divisor_access), .reg_rdata(reg_rdata));

  uip_prioritizer DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .divisor_access(divisor_access), .fifo_enable(fifo_enable), .trigger_sel(trigger_sel),
    .irq_output_enable(irq_output_enable), .char_bits(4'hA), .bit_tick(bit_tick),
    .rx_push(rx_push), .rx_push_err(rx_push_err), .rx_overrun(rx_overrun),
    .rx_fifo_reset(1'b0), .rx_count(rx_count), .rx_head_err(rx_head_err),
    .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty), .modem_delta(modem_delta),
    .line_status(line_status), .irq_out(irq_out), .irq_oe(irq_oe));

  task wrap_up;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task nap(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // settle time before each read covers the one-cycle flag update
  task rc(input [2:0] a, input [7:0] exp);
    reg [7:0] v;
    begin
      nap(2);
      host.rd(a, v);
      chk($sformatf("register %0d", a), v, exp);
    end
  endtask
  function [4:0] lv(input [1:0] s);
    lv = (s == 2'h3) ? 5'h0E : (s == 2'h2) ? 5'h08 : (s == 2'h1) ? 5'h04 : 5'h01;
  endfunction

  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    wrap_up;
  end

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    chk("line_status", line_status, 8'h60);
    rc(3'h1, 8'h00);
    rc(3'h2, 8'h01);
    host.dl(1'b1);
    host.wr(3'h1, 8'hFF);
    rc(3'h1, 8'h00);
    host.dl(1'b0);
    rc(3'h1, 8'h00);
    host.wr(3'h1, 8'hF0);
    rc(3'h1, 8'h00);
    rc(3'h7, 8'h00);
    tx_shift_empty = 1'b0;
    nap(2);
    chk("line_status", line_status, 8'h20);
    // every source but the timeout pending at once, served highest first
    tx_shift_empty = 1'b1;
    fifo_enable = 1'b1;
    irq_output_enable = 1'b1;
    host.wr(3'h1, 8'h0F);
    modem_delta = 4'h1;
    rx_overrun = 1'b1;
    rx_push = 1'b1;
    rx_push_err = 3'h2;
    rx_head_err = 3'h2;
    rx_count = 5'h01;
    nap(1);
    rx_overrun = 1'b0;
    rx_push = 1'b0;
    nap(3);
    chk("line_status", line_status, 8'hEB);
    chk("irq pin", {6'h00, irq_oe, irq_out}, 8'h03);
    rc(3'h2, 8'hC6);
    rc(3'h5, 8'hEB);
    rc(3'h2, 8'hC4);
    rx_count = 5'h00;
    rx_head_err = 3'h0;
    rx_push_err = 3'h0;
    rc(3'h2, 8'hC2);
    rc(3'h2, 8'hC0);
    host.rd(3'h6, q);
    modem_delta = 4'h0;
    rc(3'h2, 8'hC1);
    // transmit ready dropped by a holding write instead of a status read;
    // the enable must go low first, rewriting a set bit is no new enable
    host.wr(3'h1, 8'h00);
    host.wr(3'h1, 8'h02);
    nap(3);
    chk("irq_out", {7'h00, irq_out}, 8'h01);
    host.wr(3'h0, 8'h55);
    tx_fifo_empty = 1'b0;
    nap(3);
    chk("irq_out", {7'h00, irq_out}, 8'h00);
    chk("line_status", line_status, 8'h80);
    // fifo drains again: the empty edge raises transmit ready
    tx_fifo_empty = 1'b1;
    nap(3);
    chk("irq_out", {7'h00, irq_out}, 8'h01);
    rc(3'h2, 8'hC2);
    host.wr(3'h1, 8'h01);
    for (i = 0; i < 4; i = i + 1) begin
      trigger_sel = i[1:0];
      rx_count = lv(i[1:0]) - 5'h01;
      rc(3'h2, 8'hC1);
      rx_count = lv(i[1:0]);
      rc(3'h2, 8'hC4);
    end
    rx_count = 5'h00;
    nap(3);
    // timeout below the trigger level: 4 x 10 + 12 ticks after the push
    rx_count = 5'h02;
    rx_push = 1'b1;
    nap(1);
    rx_push = 1'b0;
    bit_tick = 1'b1;
    i = 0;
    while (irq_out !== 1'b1 && i < 100) begin
      nap(1);
      i = i + 1;
    end
    bit_tick = 1'b0;
    if (i == 100) begin
      errors = errors + 1;
      wrap_up;
    end
    chk("timeout ticks", {7'h00, i > 49 && i < 57}, 8'h01);
    rc(3'h2, 8'hCC);
    rx_head_err = 3'h1;
    host.wr(3'h1, 8'h05);
    host.rd(3'h0, q);
    rx_count = 5'h01;
    rc(3'h2, 8'hC6);
    host.rd(3'h5, q);
    rx_head_err = 3'h0;
    rc(3'h2, 8'hC1);
    fifo_enable = 1'b0;
    rc(3'h2, 8'h04);
    fifo_enable = 1'b1;
    host.wr(3'h1, 8'h00);
    rc(3'h2, 8'hC1);
    nap(3);
    chk("ready flag", {7'h00, line_status[0]}, 8'h01);
    wrap_up;
  end
endmodule // uip_prioritizer_tb
